// ---- include/sec_filter_pkg.sv ----
package sec_filter_pkg;

    // ------------------------------------------------------------
    // register word indices (byte address is index times four)
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_CTRL      = 6'h00;
    localparam logic [5:0] IDX_RANGE0    = 6'h01;
    localparam logic [5:0] IDX_RANGE4    = 6'h05;
    localparam logic [5:0] IDX_RANGE5    = 6'h06;
    localparam logic [5:0] IDX_LEVELS    = 6'h07;
    localparam logic [5:0] IDX_PORTS     = 6'h0E;
    localparam logic [5:0] IDX_DEC_RD    = 6'h10;
    localparam logic [5:0] IDX_DEC_WR    = 6'h11;
    localparam logic [5:0] IDX_STATUS    = 6'h14;
    localparam int         PADDR_W       = 8;
    localparam int         WORD_LSB      = 2;

    // ------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------
    localparam int          NUM_RANGES    = 6;
    localparam int          UPDATE_BIT    = 31;
    localparam int          END_LSB       = 16;
    localparam int          START_LSB     = 0;
    localparam int          BOUND_W       = 16;
    localparam int          UNIT_SHIFT    = 16;
    localparam int          DEFAULT_BIT   = 6;
    localparam int          LEVEL_W       = 7;
    localparam int          PORT_RD_LSB   = 0;
    localparam int          PORT_WR_LSB   = 16;
    localparam int          PORT_FIELD_W  = 8;
    localparam logic [31:0] PORTS_MASK    = 32'h00FF_FFFF;
    localparam int          CNT_W         = 16;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [31:0] RESET_WORD    = 32'h0000_0000;
    localparam logic [15:0] RESET_CNT     = 16'h0000;

endpackage : sec_filter_pkg

// ---- testbench/requester_model.sv ----
// ------------------------------------------------------------
// request source standing for the master ports and decoder clients
// ------------------------------------------------------------
module requester_model (
    input  wire logic        clock,
    output logic             req_valid,
    output logic             req_from_decoder,
    output logic [1:0]       req_port,
    output logic [3:0]       req_sub,
    output logic             req_write,
    output logic [31:0]      req_addr
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle values at time zero
    initial begin
        req_valid        = 1'b0;
        req_from_decoder = 1'b0;
        req_port         = 2'h0;
        req_sub          = 4'h0;
        req_write        = 1'b0;
        req_addr         = 32'h0000_0000;
    end

    // one request held for one rising edge, then fields scrambled
    task automatic issue(input logic dec, input logic [3:0] id, input logic wr,
                         input logic [31:0] addr);
        @(negedge clock);
        req_valid        = 1'b1;
        req_from_decoder = dec;
        req_port         = id[1:0];
        req_sub          = dec ? id : ~id;  // port requests carry a stray id
        req_write        = wr;
        req_addr         = addr;
        @(negedge clock);
        req_valid        = 1'b0;
        req_port         = ~id[1:0];  // stale fields must not be trusted
        req_sub          = ~id;
        req_write        = ~wr;
        req_addr         = ~addr;
    endtask : issue

endmodule : requester_model

// ---- testbench/testbench.sv ----
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        clock;
    logic        sys_rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        req_valid;
    logic        req_from_decoder;
    logic [1:0]  req_port;
    logic [3:0]  req_sub;
    logic        req_write;
    logic [31:0] req_addr;
    logic        fwd_valid;
    logic        fwd_write;
    logic [31:0] fwd_addr;
    logic        fwd_secure;
    logic        blocked;
    logic [31:0] rd_data;
    logic        rd_err;
    int          fails;
    int          checked;
    int          denied;
    logic        rd_rdy;

    localparam logic [31:0] SEC_ADDR = 32'h0010_0000;  // inside secure range four
    localparam logic [31:0] NS_ADDR  = 32'h0020_0000;  // inside non-secure range five
    logic [31:0] cls_addr [7] = '{32'h0010_0000, 32'h001F_FFFF, 32'h0018_0000,
        32'h0020_0000, 32'h0040_8000, 32'h0031_0000, 32'h000F_FFFF};
    logic        cls_sec  [7] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

    // clock at 125 MHz
    initial clock = 1'b0;
    always #4 clock = ~clock;

    ddr_security_range_filter DUT (
        .clock            (clock),
        .sys_rst          (sys_rst),
        .psel             (psel),
        .penable          (penable),
        .pwrite           (pwrite),
        .paddr            (paddr),
        .pwdata           (pwdata),
        .prdata           (prdata),
        .pready           (pready),
        .pslverr          (pslverr),
        .req_valid        (req_valid),
        .req_from_decoder (req_from_decoder),
        .req_port         (req_port),
        .req_sub          (req_sub),
        .req_write        (req_write),
        .req_addr         (req_addr),
        .fwd_valid        (fwd_valid),
        .fwd_write        (fwd_write),
        .fwd_addr         (fwd_addr),
        .fwd_secure       (fwd_secure),
        .blocked          (blocked)
    );

    requester_model far (
        .clock            (clock),
        .req_valid        (req_valid),
        .req_from_decoder (req_from_decoder),
        .req_port         (req_port),
        .req_sub          (req_sub),
        .req_write        (req_write),
        .req_addr         (req_addr)
    );

    // ------------------------------------------------------------
    // compare, bus and request tasks
    // ------------------------------------------------------------
    task automatic check_word(input string name, input logic [31:0] exp,
                              input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : check_word

    task automatic check_bit(input string name, input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %b seen %b", name, exp, got);
        end
    endtask : check_bit

    // setup phase, access phase, release with inverted data
    task automatic apb_write(input logic [5:0] idx, input logic [31:0] data);
        @(negedge clock);
        psel    = 1'b1;
        pwrite  = 1'b1;
        paddr   = {idx, 2'b00};
        pwdata  = data;
        @(negedge clock);
        penable = 1'b1;
        @(posedge clock);
        @(negedge clock);
        psel    = 1'b0;
        penable = 1'b0;
        pwdata  = ~data;
    endtask : apb_write

    // answer taken at the rising edge that ends the access phase
    task automatic apb_read(input logic [5:0] idx);
        @(negedge clock);
        psel    = 1'b1;
        pwrite  = 1'b0;
        paddr   = {idx, 2'b00};
        @(negedge clock);
        penable = 1'b1;
        @(posedge clock);
        rd_data = prdata;
        rd_err  = pslverr;
        rd_rdy  = pready;
        @(negedge clock);
        psel    = 1'b0;
        penable = 1'b0;
    endtask : apb_read

    task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp);
        apb_read(idx);
        check_word("prdata", exp, rd_data);
        check_bit("pslverr", 1'b0, rd_err);
        check_bit("pready", 1'b1, rd_rdy);
    endtask : rd_chk

    task automatic req_chk(input logic dec, input logic [3:0] id, input logic wr,
                           input logic [31:0] addr, input logic fwd, input logic sec);
        far.issue(dec, id, wr, addr);
        check_bit("fwd_valid", fwd, fwd_valid);
        check_bit("blocked", ~fwd, blocked);
        if (fwd) begin
            check_bit("fwd_secure", sec, fwd_secure);
            check_bit("fwd_write", wr, fwd_write);
            check_word("fwd_addr", addr, fwd_addr);
        end else begin
            denied++;
        end
    endtask : req_chk

    task close_out;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out

    // watchdog well beyond the expected run of about 1700 cycles
    initial begin
        #100000;
        fails++;
        close_out();
    end

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        int b;
        int c;
        fails   = 0;
        checked = 0;
        denied  = 0;
        sys_rst = 1'b1;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
        repeat (4) @(negedge clock);
        sys_rst = 0;
        rd_chk(sec_filter_pkg::IDX_RANGE0, 32'h0);
        rd_chk(sec_filter_pkg::IDX_RANGE4, 32'h0);
        rd_chk(sec_filter_pkg::IDX_RANGE5, 32'h0);
        rd_chk(sec_filter_pkg::IDX_LEVELS, 32'h0);
        rd_chk(sec_filter_pkg::IDX_PORTS, 32'h0);
        rd_chk(sec_filter_pkg::IDX_DEC_RD, 32'h0);
        rd_chk(sec_filter_pkg::IDX_DEC_WR, 32'h0);
        req_chk(1'b0, 4'h0, 1'b0, 32'h0, 1'b0, 1'b0);
        // all-ones write shows storage and dropped bits
        apb_write(sec_filter_pkg::IDX_LEVELS, 32'hFFFF_FFFF);
        rd_chk(sec_filter_pkg::IDX_LEVELS, 32'h0000_007F);
        apb_write(sec_filter_pkg::IDX_PORTS, 32'hFFFF_FFFF);
        rd_chk(sec_filter_pkg::IDX_PORTS, 32'h00FF_FFFF);
        apb_write(sec_filter_pkg::IDX_DEC_RD, 32'hFFFF_FFFF);
        rd_chk(sec_filter_pkg::IDX_DEC_RD, 32'hFFFF_FFFF);
        apb_write(sec_filter_pkg::IDX_DEC_WR, 32'hFFFF_FFFF);
        rd_chk(sec_filter_pkg::IDX_DEC_WR, 32'hFFFF_FFFF);
        rd_chk(sec_filter_pkg::IDX_CTRL, 32'h0);
        apb_write(6'h0F, 32'hFFFF_FFFF);
        apb_read(6'h0F);
        check_bit("unmapped pslverr", 1'b1, rd_err);
        check_word("unmapped prdata", 32'h0, rd_data);
        // ranges: 0 secure at 0x40, 4 secure 0x10..0x1F, 5 open 0x18..0x30
        apb_write(sec_filter_pkg::IDX_DEC_RD, 32'h0);
        apb_write(sec_filter_pkg::IDX_DEC_WR, 32'h0);
        apb_write(sec_filter_pkg::IDX_PORTS, 32'h0000_0001);
        apb_write(sec_filter_pkg::IDX_RANGE0, 32'h0040_0040);
        apb_write(sec_filter_pkg::IDX_RANGE4, 32'h001F_0010);
        apb_write(sec_filter_pkg::IDX_RANGE5, 32'h0030_0018);
        apb_write(sec_filter_pkg::IDX_LEVELS, 32'h0000_0011);
        rd_chk(sec_filter_pkg::IDX_RANGE4, 32'h001F_0010);
        rd_chk(sec_filter_pkg::IDX_RANGE5, 32'h0030_0018);
        req_chk(1'b0, 4'h0, 1'b0, SEC_ADDR, 1'b1, 1'b0);
        apb_write(sec_filter_pkg::IDX_CTRL, 32'h8000_0000);
        // only non-secure reads of port zero are open
        for (b = 0; b < 7; b++) begin
            req_chk(1'b0, 4'h0, 1'b0, cls_addr[b], !cls_sec[b], 1'b0);
        end
        // each port enable bit alone against every port, direction and class
        for (b = 0; b < 16; b++) begin
            apb_write(sec_filter_pkg::IDX_PORTS, 32'h1 << (16 * b[3] + b[2:0]));
            for (c = 0; c < 16; c++) begin
                req_chk(1'b0, {2'b00, c[2:1]}, c[3], c[0] ? SEC_ADDR : NS_ADDR,
                        b == c, c[0]);
            end
        end
        // each decoder enable bit alone, port enables all open
        apb_write(sec_filter_pkg::IDX_PORTS, 32'hFFFF_FFFF);
        for (b = 0; b < 64; b++) begin
            apb_write(b[5] ? sec_filter_pkg::IDX_DEC_WR : sec_filter_pkg::IDX_DEC_RD,
                      32'h1 << b[4:0]);
            apb_write(b[5] ? sec_filter_pkg::IDX_DEC_RD : sec_filter_pkg::IDX_DEC_WR,
                      32'h0);
            for (c = 0; c < 4; c++) begin
                req_chk(1'b1, b[4:1], c[1], c[0] ? SEC_ADDR : NS_ADDR,
                        (c[1] == b[5]) && (c[0] == b[0]), c[0]);
            end
            req_chk(1'b1, b[4:1] ^ 4'h1, b[5], b[0] ? SEC_ADDR : NS_ADDR,
                    1'b0, b[0]);
        end
        // secure default region
        apb_write(sec_filter_pkg::IDX_LEVELS, 32'h0000_0050);
        apb_write(sec_filter_pkg::IDX_CTRL, 32'h8000_0000);
        apb_write(sec_filter_pkg::IDX_DEC_WR, 32'h0);
        apb_write(sec_filter_pkg::IDX_DEC_RD, 32'h0000_0002);
        req_chk(1'b1, 4'h0, 1'b0, 32'h0031_0000, 1'b1, 1'b1);
        req_chk(1'b1, 4'h0, 1'b0, NS_ADDR, 1'b0, 1'b0);
        // status word counts every refused request
        rd_chk(sec_filter_pkg::IDX_STATUS, 32'(denied));
        close_out();
    end

endmodule : testbench

// ---- verilog/ddr_security_range_filter.sv ----
module ddr_security_range_filter (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        req_valid,
    input  wire logic        req_from_decoder,
    input  wire logic [1:0]  req_port,
    input  wire logic [3:0]  req_sub,
    input  wire logic        req_write,
    input  wire logic [31:0] req_addr,
    output logic             fwd_valid,
    output logic             fwd_write,
    output logic [31:0]      fwd_addr,
    output logic             fwd_secure,
    output logic             blocked
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // enable bit for requester n and region class
    function automatic logic perm_bit(input logic [31:0] vec,
                                      input logic [3:0]  n,
                                      input logic        sec);
        return vec[{n, sec}];
    endfunction : perm_bit

    // known register index
    function automatic logic is_mapped(input logic [5:0] idx);
        return (idx <= sec_filter_pkg::IDX_LEVELS) ||
               (idx == sec_filter_pkg::IDX_PORTS) ||
               (idx == sec_filter_pkg::IDX_DEC_RD) ||
               (idx == sec_filter_pkg::IDX_DEC_WR) ||
               (idx == sec_filter_pkg::IDX_STATUS);
    endfunction : is_mapped

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [5:0][31:0] bounds_r;
    logic [5:0][31:0] bounds_nxt;
    logic [5:0][31:0] shadow_bounds_r;
    logic [5:0][31:0] shadow_bounds_nxt;
    logic [6:0]       levels_r;
    logic [6:0]       levels_nxt;
    logic [6:0]       shadow_levels_r;
    logic [6:0]       shadow_levels_nxt;
    logic [31:0]      ports_r;
    logic [31:0]      ports_nxt;
    logic [31:0]      dec_rd_r;
    logic [31:0]      dec_rd_nxt;
    logic [31:0]      dec_wr_r;
    logic [31:0]      dec_wr_nxt;
    logic [31:0]      prdata_r;
    logic [31:0]      prdata_nxt;
    logic [15:0]      viol_cnt_r;
    logic [15:0]      viol_cnt_nxt;
    logic             fwd_valid_r;
    logic             fwd_valid_nxt;
    logic             fwd_write_r;
    logic             fwd_write_nxt;
    logic [31:0]      fwd_addr_r;
    logic [31:0]      fwd_addr_nxt;
    logic             fwd_secure_r;
    logic             fwd_secure_nxt;
    logic             blocked_r;
    logic             blocked_nxt;

    logic [5:0]       idx;
    logic             wr_en;
    logic             rd_setup;
    logic             shadow_update;
    logic             req_secure;
    logic [31:0]      perm_vec;
    logic [3:0]       perm_idx;
    logic             allowed;

    // ------------------------------------------------------------
    // peripheral bus decode
    // ------------------------------------------------------------
    // word index from byte address
    assign idx      = paddr[sec_filter_pkg::WORD_LSB +: 6];
    assign wr_en    = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign pready   = 1'b1;             // zero wait states
    assign pslverr  = psel && penable && !is_mapped(idx);
    assign prdata   = prdata_r;

    assign shadow_update = wr_en && (idx == sec_filter_pkg::IDX_CTRL) &&
                           pwdata[sec_filter_pkg::UPDATE_BIT];

    // ------------------------------------------------------------
    // register file next state
    // ------------------------------------------------------------
    // programmed copies, shadow copies and read data
    always_comb begin
        bounds_nxt        = bounds_r;
        levels_nxt        = levels_r;
        ports_nxt         = ports_r;
        dec_rd_nxt        = dec_rd_r;
        dec_wr_nxt        = dec_wr_r;
        shadow_bounds_nxt = shadow_bounds_r;
        shadow_levels_nxt = shadow_levels_r;
        prdata_nxt        = prdata_r;
        if (wr_en) begin
            // six range words from index 1
            for (int i = 0; i < sec_filter_pkg::NUM_RANGES; i++) begin
                if (idx == 6'(sec_filter_pkg::IDX_RANGE0 + i)) begin
                    bounds_nxt[i] = pwdata;
                end
            end
            case (idx)
                // levels and default, upper bits dropped
                sec_filter_pkg::IDX_LEVELS: begin
                    levels_nxt = pwdata[sec_filter_pkg::LEVEL_W-1:0];
                end
                // top byte unused, middle byte stored
                sec_filter_pkg::IDX_PORTS: begin
                    ports_nxt = pwdata & sec_filter_pkg::PORTS_MASK;
                end
                sec_filter_pkg::IDX_DEC_RD: begin
                    dec_rd_nxt = pwdata;
                end
                sec_filter_pkg::IDX_DEC_WR: begin
                    dec_wr_nxt = pwdata;
                end
                default: begin
                end
            endcase
        end
        // copy programmed ranges into active shadow
        if (shadow_update) begin
            shadow_bounds_nxt = bounds_r;
            shadow_levels_nxt = levels_r;
        end
        // read data latched in setup phase, valid in access phase
        if (rd_setup) begin
            prdata_nxt = sec_filter_pkg::RESET_WORD;
            if (idx >= sec_filter_pkg::IDX_RANGE0 && idx <= sec_filter_pkg::IDX_RANGE5) begin
                prdata_nxt = bounds_r[3'(idx - sec_filter_pkg::IDX_RANGE0)];
            end
            case (idx)
                sec_filter_pkg::IDX_LEVELS: prdata_nxt = {25'h0000000, levels_r};
                sec_filter_pkg::IDX_PORTS:  prdata_nxt = ports_r;
                sec_filter_pkg::IDX_DEC_RD: prdata_nxt = dec_rd_r;
                sec_filter_pkg::IDX_DEC_WR: prdata_nxt = dec_wr_r;
                sec_filter_pkg::IDX_STATUS: prdata_nxt = {16'h0000, viol_cnt_r};
                default: begin
                end
            endcase
        end
    end

    // register file storage
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            bounds_r        <= '0;
            shadow_bounds_r <= '0;
            levels_r        <= 7'h00;
            shadow_levels_r <= 7'h00;
            ports_r         <= sec_filter_pkg::RESET_WORD;
            dec_rd_r        <= sec_filter_pkg::RESET_WORD;
            dec_wr_r        <= sec_filter_pkg::RESET_WORD;
            prdata_r        <= sec_filter_pkg::RESET_WORD;
        end else begin
            bounds_r        <= bounds_nxt;
            shadow_bounds_r <= shadow_bounds_nxt;
            levels_r        <= levels_nxt;
            shadow_levels_r <= shadow_levels_nxt;
            ports_r         <= ports_nxt;
            dec_rd_r        <= dec_rd_nxt;
            dec_wr_r        <= dec_wr_nxt;
            prdata_r        <= prdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // request classification and permission check
    // ------------------------------------------------------------
    range_classifier u_classifier (
        .bounds    (shadow_bounds_r),
        .levels    (shadow_levels_r),
        .addr_unit (req_addr[sec_filter_pkg::UNIT_SHIFT +: sec_filter_pkg::BOUND_W]),
        .secure    (req_secure)
    );

    // select the enable vector of the requester
    always_comb begin
        perm_idx = {2'b00, req_port};
        if (req_from_decoder) begin
            perm_idx = req_sub;
            perm_vec = req_write ? dec_wr_r : dec_rd_r;
        end else if (req_write) begin
            perm_vec = {24'h000000, ports_r[sec_filter_pkg::PORT_WR_LSB +: 8]};
        end else begin
            perm_vec = {24'h000000, ports_r[sec_filter_pkg::PORT_RD_LSB +: 8]};
        end
    end

    assign allowed = perm_bit(perm_vec, perm_idx, req_secure);

    // ------------------------------------------------------------
    // forward or block
    // ------------------------------------------------------------
    // one cycle decision, result registered
    always_comb begin
        fwd_valid_nxt  = 1'b0;
        blocked_nxt    = 1'b0;
        fwd_write_nxt  = fwd_write_r;
        fwd_addr_nxt   = fwd_addr_r;
        fwd_secure_nxt = fwd_secure_r;
        viol_cnt_nxt   = viol_cnt_r;
        if (req_valid) begin
            fwd_valid_nxt = allowed;
            blocked_nxt   = !allowed;
            if (allowed) begin
                fwd_write_nxt  = req_write;
                fwd_addr_nxt   = req_addr;
                fwd_secure_nxt = req_secure;
            end else if (viol_cnt_r != 16'hFFFF) begin
                viol_cnt_nxt = viol_cnt_r + 16'h0001;  // saturating
            end
        end
    end

    // forward path registers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            fwd_valid_r  <= 1'b0;
            blocked_r    <= 1'b0;
            fwd_write_r  <= 1'b0;
            fwd_addr_r   <= sec_filter_pkg::RESET_WORD;
            fwd_secure_r <= 1'b0;
            viol_cnt_r   <= sec_filter_pkg::RESET_CNT;
        end else begin
            fwd_valid_r  <= fwd_valid_nxt;
            blocked_r    <= blocked_nxt;
            fwd_write_r  <= fwd_write_nxt;
            fwd_addr_r   <= fwd_addr_nxt;
            fwd_secure_r <= fwd_secure_nxt;
            viol_cnt_r   <= viol_cnt_nxt;
        end
    end

    assign fwd_valid  = fwd_valid_r;
    assign fwd_write  = fwd_write_r;
    assign fwd_addr   = fwd_addr_r;
    assign fwd_secure = fwd_secure_r;
    assign blocked    = blocked_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    range_four_a: assert property (wr_en && idx == sec_filter_pkg::IDX_RANGE4
        |=> bounds_r[4] == $past(pwdata)) else $error("range four not stored");
    range_five_a: assert property (wr_en && idx == sec_filter_pkg::IDX_RANGE5
        |=> bounds_r[5] == $past(pwdata)) else $error("range five not stored");
    level_unused_a: assert property (rd_setup && idx == sec_filter_pkg::IDX_LEVELS
        |=> prdata[31:7] == 25'h0000000) else $error("level upper bits set");
    port_unused_a: assert property (rd_setup && idx == sec_filter_pkg::IDX_PORTS
        |=> prdata[31:24] == 8'h00) else $error("port top byte set");
    port_read_a: assert property (req_valid && !req_from_decoder && !req_write
        |-> allowed == ports_r[{1'b0, req_port, req_secure}]) else $error("port read perm");
    port_write_a: assert property (req_valid && !req_from_decoder && req_write
        |-> allowed == ports_r[{2'b10, req_port, req_secure}]) else $error("port write perm");
    dec_read_a: assert property (req_valid && req_from_decoder && !req_write
        |-> allowed == dec_rd_r[{req_sub, req_secure}]) else $error("decoder read perm");
    dec_write_a: assert property (req_valid && req_from_decoder && req_write
        |-> allowed == dec_wr_r[{req_sub, req_secure}]) else $error("decoder write perm");
    shadow_copy_a: assert property (shadow_update
        |=> shadow_levels_r == $past(levels_r) && shadow_bounds_r == $past(bounds_r))
        else $error("shadow not updated");
    shadow_hold_a: assert property (!shadow_update
        |=> $stable(shadow_levels_r) && $stable(shadow_bounds_r)) else $error("shadow moved");
    range_zero_a: assert property (req_valid &&
        req_addr[31:16] >= shadow_bounds_r[0][15:0] &&
        req_addr[31:16] <= shadow_bounds_r[0][31:16]
        |-> req_secure == shadow_levels_r[0]) else $error("range zero priority");
    deny_fwd_a: assert property (req_valid && !allowed
        |=> blocked && !fwd_valid) else $error("denied request forwarded");
    grant_fwd_a: assert property (req_valid && allowed
        |=> fwd_valid && !blocked && fwd_addr == $past(req_addr)) else $error("grant lost");

    grant_c:  cover property (req_valid && allowed ##1 fwd_valid);
    block_c:  cover property (req_valid && !allowed ##1 blocked);
    shadow_c: cover property (shadow_update ##1 req_valid && req_secure);
    dec_c:    cover property (req_valid && req_from_decoder && req_secure && allowed);

endmodule : ddr_security_range_filter

// ---- verilog/range_classifier.sv ----
module range_classifier (
    input  wire logic [5:0][31:0] bounds,
    input  wire logic [6:0]       levels,
    input  wire logic [15:0]      addr_unit,
    output logic                  secure
);

    // ------------------------------------------------------------
    // region lookup
    // ------------------------------------------------------------
    // scan from the top range down so the lowest numbered hit wins
    always_comb begin
        logic [15:0] lo;
        logic [15:0] hi;
        lo = 16'h0000;
        hi = 16'h0000;
        secure = levels[sec_filter_pkg::DEFAULT_BIT];
        for (int i = sec_filter_pkg::NUM_RANGES - 1; i >= 0; i--) begin
            hi = bounds[i][sec_filter_pkg::END_LSB +: sec_filter_pkg::BOUND_W];
            lo = bounds[i][sec_filter_pkg::START_LSB +: sec_filter_pkg::BOUND_W];
            if (addr_unit >= lo && addr_unit <= hi) begin
                secure = levels[i];
            end
        end
    end

endmodule : range_classifier
